// *** src/uep_ep0_ctrl.sv ***
// Endpoint 0 control/status low byte, device mode, with interrupt status and mask.
// Assumes a classic Wishbone master that holds each request until it sees ack, and
// a packet engine whose event inputs are one-cycle pulses synchronous to clk_i.
// Function
// - Writing one to bit 7 clears setup end
// - Writing one to bit 6 clears receive ready
// - Send-stall bit requests STALL, ends transaction
// - Send-stall self-clears after STALL went out
// - Early control end sets flag and interrupt
// - Data-end marker clears itself automatically
// - Stall-sent flag set by STALL, software clears
// - Software transmit-ready raises endpoint interrupt flag
// - Transmit-ready clears after packet is sent
// - Received packet sets receive ready, interrupt
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

module uep_ep0_ctrl
  import uep_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire uep_pkg::uep_wb_req_t wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire uep_pkg::uep_link_evt_t evt_i,
  output uep_pkg::uep_link_ctl_t link_o,
  output logic irq_o
);
  import uep_pkg::*;

  // Registered state and its next value
  uep_state_t st_ff;
  uep_state_t nxt_st;

  // Bus decode helpers
  logic req; // Master has a request on the bus
  logic wr_go; // Write commits on the edge that samples ack
  logic csr_wr; // Write to the control/status byte
  logic ists_wr; // Write to interrupt status
  logic imask_wr; // Write to interrupt mask
  logic [7:0] wdat; // Low write byte
  logic early_end; // Control transfer ended before data-end was set
  logic ep0_evt; // Any event that raises the endpoint 0 interrupt flag

  // Matches a byte address against a register index
  function automatic logic idx_is(input logic [ADR_W-1:0] adr, input logic [IDX_W-1:0] idx);
    idx_is = (adr[ADR_W-1:2] == idx);
  endfunction

  // Packs the readable view of the control/status byte
  function automatic logic [7:0] csr_view(input uep_state_t s);
    logic [7:0] v;
    v = CSRL_RESET;
    // Clear strobes at bits 7 and 6 always read zero
    v[BIT_SEND_STALL] = s.send_stall;
    v[BIT_EARLY_END] = s.early_control_end_flag;
    v[BIT_LAST_DATA] = s.last_data_marker;
    v[BIT_STALL_SENT] = s.stall_sent;
    v[BIT_TX_READY] = s.tx_packet_ready;
    v[BIT_RX_READY] = s.rx_packet_ready;
    csr_view = v;
  endfunction

  // Request and write strobes; only byte lane 0 carries data
  assign req = wb_i.cyc && wb_i.stb;
  assign wr_go = req && wb_i.we && st_ff.ack && wb_i.sel[0];
  assign csr_wr = wr_go && idx_is(wb_i.adr, CSRL_IDX);
  assign ists_wr = wr_go && idx_is(wb_i.adr, INT_STATUS_IDX);
  assign imask_wr = wr_go && idx_is(wb_i.adr, INT_MASK_IDX);
  assign wdat = wb_i.dat[7:0];

  // An end of transfer counts as early only while no data-end is pending
  assign early_end = evt_i.ctrl_end && !st_ff.last_data_marker;
  assign ep0_evt = early_end || (csr_wr && wdat[BIT_TX_READY]) || evt_i.rx_done;

  // Next-state logic; every flag lets its set win over a clear
  always_comb
  begin
    nxt_st = st_ff;

    // Ack one cycle after the request rises, then drop for a cycle
    nxt_st.ack = req && !st_ff.ack;

    // Read data is captured with ack; unmapped addresses read zero
    nxt_st.rdat = '0;
    if (req && !st_ff.ack && !wb_i.we)
    begin
      if (idx_is(wb_i.adr, CSRL_IDX))
      begin
        nxt_st.rdat[7:0] = csr_view(st_ff);
      end
      else if (idx_is(wb_i.adr, INT_STATUS_IDX))
      begin
        nxt_st.rdat[INT_W-1:0] = st_ff.transmit_interrupt_status;
      end
      else if (idx_is(wb_i.adr, INT_MASK_IDX))
      begin
        nxt_st.rdat[INT_W-1:0] = st_ff.int_mask;
      end
    end

    // Send stall: a write of one requests it, the engine's report ends it
    if (csr_wr && wdat[BIT_SEND_STALL])
    begin
      nxt_st.send_stall = 1'b1;
    end
    else if (evt_i.stall_sent)
    begin
      nxt_st.send_stall = 1'b0;
    end

    // Setup end: set on early end, cleared by the clear strobe
    if (early_end)
    begin
      nxt_st.early_control_end_flag = 1'b1;
    end
    else if (csr_wr && wdat[BIT_SETUP_END_CLEAR])
    begin
      nxt_st.early_control_end_flag = 1'b0;
    end

    // Data-end marker: software sets it, the end of the transfer clears it
    if (csr_wr && wdat[BIT_LAST_DATA])
    begin
      nxt_st.last_data_marker = 1'b1;
    end
    else if (evt_i.ctrl_end)
    begin
      nxt_st.last_data_marker = 1'b0;
    end

    // Stall sent: sticky until software writes the bit as zero
    if (evt_i.stall_sent)
    begin
      nxt_st.stall_sent = 1'b1;
    end
    else if (csr_wr && !wdat[BIT_STALL_SENT])
    begin
      nxt_st.stall_sent = 1'b0;
    end

    // Transmit ready: writing zero has no effect, only the engine clears it
    if (csr_wr && wdat[BIT_TX_READY])
    begin
      nxt_st.tx_packet_ready = 1'b1;
    end
    else if (evt_i.tx_done)
    begin
      nxt_st.tx_packet_ready = 1'b0;
    end

    // Receive ready: set by a received packet, cleared by the ack strobe
    if (evt_i.rx_done)
    begin
      nxt_st.rx_packet_ready = 1'b1;
    end
    else if (csr_wr && wdat[BIT_RX_ACK_CLEAR])
    begin
      nxt_st.rx_packet_ready = 1'b0;
    end

    // Sticky interrupt status, write one to clear, new events win
    if (ists_wr)
    begin
      nxt_st.transmit_interrupt_status = st_ff.transmit_interrupt_status & ~wdat[INT_W-1:0];
    end
    nxt_st.transmit_interrupt_status[INT_EP0] = nxt_st.transmit_interrupt_status[INT_EP0] | ep0_evt;
    nxt_st.transmit_interrupt_status[INT_STALL] = nxt_st.transmit_interrupt_status[INT_STALL] | evt_i.stall_sent;
    nxt_st.transmit_interrupt_status[INT_TX_DONE] = nxt_st.transmit_interrupt_status[INT_TX_DONE] | evt_i.tx_done;

    // Mask is plain read/write
    if (imask_wr)
    begin
      nxt_st.int_mask = wdat[INT_W-1:0];
    end

    // Level interrupt, registered so the pin comes from a flip-flop
    nxt_st.irq = |(nxt_st.transmit_interrupt_status & nxt_st.int_mask);
  end

  // State register with synchronous reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= STATE_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdat;
  assign link_o.send_stall = st_ff.send_stall;
  assign link_o.tx_packet_ready = st_ff.tx_packet_ready;
  assign link_o.rx_packet_ready = st_ff.rx_packet_ready;
  assign link_o.last_data_marker = st_ff.last_data_marker;
  assign irq_o = st_ff.irq;

  // Checks on the behaviour above
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // A write of the clear strobe with no early end the same cycle
  sequence s_early_control_end_flag_clear;
    csr_wr && wdat[BIT_SETUP_END_CLEAR] && !early_end;
  endsequence

  // A received packet, then the flag visible one cycle later
  sequence s_rx_seen;
    evt_i.rx_done ##1 (link_o.rx_packet_ready && st_ff.transmit_interrupt_status[INT_EP0]);
  endsequence

  // Request rises, ack follows for one cycle
  sequence s_bus_answer;
    ##1 wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_early_control_end_flag_clear: assert property (s_early_control_end_flag_clear |=> !st_ff.early_control_end_flag)
    else $error("setup end flag not cleared by strobe");

  a_rx_ack_clear: assert property (csr_wr && wdat[BIT_RX_ACK_CLEAR] && !evt_i.rx_done
    |=> !link_o.rx_packet_ready)
    else $error("receive ready not cleared by strobe");

  a_stall_request: assert property (csr_wr && wdat[BIT_SEND_STALL] |=> link_o.send_stall)
    else $error("send stall not requested");

  a_stall_self_clear: assert property (evt_i.stall_sent && !(csr_wr && wdat[BIT_SEND_STALL])
    |=> !link_o.send_stall)
    else $error("send stall not cleared after handshake");

  a_early_end_flag: assert property (evt_i.ctrl_end && !link_o.last_data_marker
    |=> st_ff.early_control_end_flag && st_ff.transmit_interrupt_status[INT_EP0])
    else $error("early end not flagged");

  a_no_early_end: assert property (evt_i.ctrl_end && link_o.last_data_marker
    && !st_ff.early_control_end_flag |=> !st_ff.early_control_end_flag)
    else $error("early end flagged after data end");

  a_data_end_auto: assert property (evt_i.ctrl_end && !(csr_wr && wdat[BIT_LAST_DATA])
    |=> !link_o.last_data_marker)
    else $error("data end marker not cleared");

  a_stall_sent_set: assert property (evt_i.stall_sent |=> st_ff.stall_sent [*2]
    or (st_ff.stall_sent ##1 $past(csr_wr)))
    else $error("stall sent flag not held");

  a_tx_ready_int: assert property (csr_wr && wdat[BIT_TX_READY]
    |=> link_o.tx_packet_ready && st_ff.transmit_interrupt_status[INT_EP0])
    else $error("transmit ready or interrupt flag missing");

  a_tx_ready_auto: assert property (evt_i.tx_done && !(csr_wr && wdat[BIT_TX_READY])
    |=> !link_o.tx_packet_ready)
    else $error("transmit ready not cleared after send");

  a_rx_ready_set: assert property (evt_i.rx_done |-> s_rx_seen)
    else $error("receive ready or interrupt flag missing");

  a_zero_write: assert property (csr_wr && wdat[7:3] == 5'h00 && !wdat[BIT_TX_READY]
    && evt_i == '0 |=> $stable(link_o) && $stable(st_ff.early_control_end_flag))
    else $error("zero write changed a flag");

  a_bus_answer: assert property ($rose(req) |-> s_bus_answer)
    else $error("bus ack not one cycle after request");

  // The pin is registered from next-state values, so it must match the stored status and mask
  a_irq_level: assert property (irq_o == |(st_ff.transmit_interrupt_status & st_ff.int_mask))
    else $error("interrupt level wrong");

  // Read data is zero outside the ack cycle, so a late sample never sees stale data
  a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");

  // Only the low byte of any register carries data
  a_upper_bytes_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bytes not zero");

  // Bits 7 and 6 are clear strobes and never read back as one
  a_strobes_read_zero: assert property (wb_ack_o && idx_is($past(wb_i.adr), CSRL_IDX)
    |-> wb_dat_o[7:6] == 2'h0)
    else $error("clear strobe read back as one");

  // Writing zero to the stall-sent bit clears it unless a new handshake arrives
  a_stall_sent_clear: assert property (csr_wr && !wdat[BIT_STALL_SENT] && !evt_i.stall_sent
    |=> !st_ff.stall_sent)
    else $error("stall sent flag not cleared by zero write");

  // A transmitted packet is recorded in the status register
  a_tx_done_status: assert property (evt_i.tx_done |=> st_ff.transmit_interrupt_status[INT_TX_DONE])
    else $error("transmit done not recorded");

  // A new event beats a write-one-to-clear in the same cycle
  a_status_set_wins: assert property (ists_wr && wdat[INT_STALL] && evt_i.stall_sent
    |=> st_ff.transmit_interrupt_status[INT_STALL])
    else $error("status clear beat a new event");

  // Write one to clear drops the endpoint flag when nothing new raises it
  a_status_w1c: assert property (ists_wr && wdat[INT_EP0] && !ep0_evt
    |=> !st_ff.transmit_interrupt_status[INT_EP0])
    else $error("endpoint flag not cleared by write one");

  // The mask holds exactly what software wrote
  a_mask_write: assert property (imask_wr |=> st_ff.int_mask == $past(wdat[INT_W-1:0]))
    else $error("mask not written");

  // A write-set of the data-end marker wins over the end of the transfer
  a_data_end_set: assert property (csr_wr && wdat[BIT_LAST_DATA] |=> link_o.last_data_marker)
    else $error("data end marker not set");

  // A received packet beats the acknowledge strobe in the same cycle
  a_rx_set_wins: assert property (evt_i.rx_done && csr_wr && wdat[BIT_RX_ACK_CLEAR]
    |=> link_o.rx_packet_ready)
    else $error("receive ready lost to clear strobe");

  // A held request gets ack on alternate cycles, never two in a row
  a_single_ack: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");

  // Writes with byte lane 0 off change nothing in the control byte
  a_lane_off_write: assert property (req && wb_i.we && st_ff.ack && !wb_i.sel[0] && evt_i == '0
    |=> $stable(link_o))
    else $error("write with lane 0 off changed a flag");

endmodule

`default_nettype wire

// *** src/uep_pkg.sv ***
// Constants, register map and carrier types of the endpoint 0 control/status block.
// Assumes a 32-bit classic Wishbone bus with byte addresses and a USB packet engine
// that reports its events as one-cycle pulses on the same clock.
package uep_pkg;

  // Bus byte address width in bits; word index is adr[ADR_W-1:2]
  localparam int ADR_W = 12;
  localparam int IDX_W = ADR_W - 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] CSRL_IDX = 10'h102;
  localparam logic [IDX_W-1:0] INT_STATUS_IDX = 10'h110;
  localparam logic [IDX_W-1:0] INT_MASK_IDX = 10'h111;

  // Field positions of endpoint0_control_status_low
  localparam int BIT_SETUP_END_CLEAR = 7;
  localparam int BIT_RX_ACK_CLEAR = 6;
  localparam int BIT_SEND_STALL = 5;
  localparam int BIT_EARLY_END = 4;
  localparam int BIT_LAST_DATA = 3;
  localparam int BIT_STALL_SENT = 2;
  localparam int BIT_TX_READY = 1;
  localparam int BIT_RX_READY = 0;

  // Interrupt status and mask layout
  localparam int INT_W = 3;
  localparam int INT_EP0 = 0;
  localparam int INT_STALL = 1;
  localparam int INT_TX_DONE = 2;

  // Values after reset
  localparam logic [7:0] CSRL_RESET = 8'h00;
  localparam logic [INT_W-1:0] INT_RESET = 3'h0;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } uep_wb_req_t;

  // One-cycle event pulses from the packet engine
  typedef struct packed {
    logic stall_sent;
    logic tx_done;
    logic rx_done;
    logic ctrl_end;
  } uep_link_evt_t;

  // Levels towards the packet engine
  typedef struct packed {
    logic send_stall;
    logic tx_packet_ready;
    logic rx_packet_ready;
    logic last_data_marker;
  } uep_link_ctl_t;

  // Whole state of the block
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic send_stall;
    logic early_control_end_flag;
    logic last_data_marker;
    logic stall_sent;
    logic tx_packet_ready;
    logic rx_packet_ready;
    logic [INT_W-1:0] transmit_interrupt_status;
    logic [INT_W-1:0] int_mask;
    logic irq;
  } uep_state_t;

  localparam uep_state_t STATE_RESET = '0;

endpackage

// *** testbench/uep_host_model.sv ***
// Behavioural packet engine and USB host facing the endpoint 0 block.
// Assumes the block's link levels on clk_i; stall and transmit answers come dly_i cycles late.
`timescale 1ns/1ns
`default_nettype none

module uep_host_model
  import uep_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire uep_pkg::uep_link_ctl_t link_i,
  input wire logic [7:0] dly_i,
  input wire logic rx_req_i,
  input wire logic end_req_i,
  output uep_pkg::uep_link_evt_t evt_o
);
  logic [7:0] st_ff; // Cycles the stall request has stood
  logic [7:0] tx_ff; // Cycles the transmit request has stood

  // One pulse per request level, so a late clear by the block never double-fires
  always_ff @(posedge clk_i)
  begin
    evt_o <= '0;
    st_ff <= link_i.send_stall ? st_ff + 8'h01 : 8'h00;
    tx_ff <= link_i.tx_packet_ready ? tx_ff + 8'h01 : 8'h00;
    if (rst_i)
    begin
      st_ff <= 8'h00;
      tx_ff <= 8'h00;
    end
    else
    begin
      evt_o.rx_done <= rx_req_i;
      evt_o.ctrl_end <= end_req_i;
      evt_o.stall_sent <= link_i.send_stall && st_ff == dly_i;
      evt_o.tx_done <= link_i.tx_packet_ready && tx_ff == dly_i;
    end
  end
endmodule

`default_nettype wire

// *** testbench/uep_ep0_ctrl_tb.sv ***
// Self-checking bench for the endpoint 0 control/status block.
// Assumes the host model on the link side and a Wishbone master built from tasks.
`timescale 1ns/1ns
`default_nettype none

module uep_ep0_ctrl_tb;
  import uep_pkg::*;
  logic clk_i;
  logic rst_i;
  uep_wb_req_t wb;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic [31:0] rdat;
  uep_link_evt_t evt;
  uep_link_ctl_t link;
  logic irq_o;
  logic [7:0] dly;
  logic rx_req;
  logic end_req;
  int fails;
  int n_compared;

  uep_ep0_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .evt_i(evt), .link_o(link), .irq_o(irq_o));
  uep_host_model host (.clk_i(clk_i), .rst_i(rst_i), .link_i(link), .dly_i(dly), .rx_req_i(rx_req),
    .end_req_i(end_req), .evt_o(evt));

  // 125 MHz clock
  always #4 clk_i = ~clk_i;

  // Compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One classic cycle; entered just after a rising edge
  task acc(input logic w, input logic [9:0] ix, input logic [7:0] d);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {ix, 2'b00}, sel: 4'h1, dat: {24'h0, d}};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb <= '0;
    @(posedge clk_i);
  endtask

  task rd(input string nm, input logic [9:0] ix, input logic [7:0] e);
    acc(1'b0, ix, 8'h00);
    chk(nm, rdat, {24'h0, e});
  endtask

  // Received packet when r is high, end of control transfer otherwise
  task ev(input logic r);
    rx_req <= r;
    end_req <= !r;
    @(posedge clk_i);
    rx_req <= 1'b0;
    end_req <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Cuts a hang; the tests need well under 1000 cycles
  initial
  begin
    repeat (3000) @(posedge clk_i);
    fails++;
    print_verdict;
  end

  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    wb = '0;
    dly = 8'h08;
    rx_req = 1'b0;
    end_req = 1'b0;
    fails = 0;
    n_compared = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("csrl", CSRL_IDX, 8'h00);
    rd("mask", INT_MASK_IDX, 8'h00);
    rd("unmapped", 10'h3ff, 8'h00);
    $display("test reset done");
    acc(1'b1, INT_MASK_IDX, 8'h07);
    ev(1'b1);
    rd("mask", INT_MASK_IDX, 8'h07);
    rd("csrl", CSRL_IDX, 8'h01);
    chk("link", link, 32'h2);
    rd("status", INT_STATUS_IDX, 8'h01);
    chk("irq", irq_o, 32'h1);
    acc(1'b1, CSRL_IDX, 8'h00);
    chk("idle data", wb_dat_o, 32'h0);
    rd("csrl", CSRL_IDX, 8'h01);
    acc(1'b1, CSRL_IDX, 8'h40);
    rd("csrl", CSRL_IDX, 8'h00);
    acc(1'b1, INT_STATUS_IDX, 8'h01);
    rd("status", INT_STATUS_IDX, 8'h00);
    chk("irq", irq_o, 32'h0);
    $display("test rx done");
    acc(1'b1, CSRL_IDX, 8'h0a);
    chk("link", link, 32'h5);
    rd("csrl", CSRL_IDX, 8'h0a);
    rd("status", INT_STATUS_IDX, 8'h01);
    repeat (12) @(posedge clk_i);
    rd("csrl", CSRL_IDX, 8'h08);
    rd("status", INT_STATUS_IDX, 8'h05);
    ev(1'b0);
    rd("csrl", CSRL_IDX, 8'h00);
    $display("test tx done");
    acc(1'b1, INT_STATUS_IDX, 8'h07);
    ev(1'b0);
    rd("csrl", CSRL_IDX, 8'h10);
    rd("status", INT_STATUS_IDX, 8'h01);
    acc(1'b1, CSRL_IDX, 8'h80);
    rd("csrl", CSRL_IDX, 8'h00);
    $display("test early end done");
    acc(1'b1, CSRL_IDX, 8'h20);
    chk("stall", link.send_stall, 32'h1);
    rd("csrl", CSRL_IDX, 8'h20);
    repeat (12) @(posedge clk_i);
    rd("csrl", CSRL_IDX, 8'h04);
    acc(1'b1, CSRL_IDX, 8'h04);
    rd("csrl", CSRL_IDX, 8'h04);
    acc(1'b1, CSRL_IDX, 8'h00);
    rd("csrl", CSRL_IDX, 8'h00);
    $display("test stall done");
    dly <= 8'h00;
    acc(1'b1, CSRL_IDX, 8'h02);
    repeat (4) @(posedge clk_i);
    rd("csrl", CSRL_IDX, 8'h00);
    rd("status", INT_STATUS_IDX, 8'h07);
    chk("irq", irq_o, 32'h1);
    $display("test prompt tx done");
    print_verdict;
  end
endmodule

`default_nettype wire
